// *** logic/async_serial_receiver.sv ***
// Asynchronous serial receiver with AXI4-Lite register access
//
// Behaviour
// - x16 recovery stage, shift register per bit
// - Reception starts only with continuous receive enable
// - After stop bit, word enters buffer if space
// - Word transfer sets ready flag; enable gates interrupt
// - Ready flag read-only, clears when buffer empty
// - Buffer is two-entry in-order queue
// - Stop bit with full buffer sets overrun
// - Overrun blocks all transfers into buffer
// - Clearing receive enable clears overrun
// - Missing stop bit sets framing error
// - Framing error, ninth bit queued per word
// - Each bit decided by three-sample majority
// - Samples on seventh, eighth, ninth edges
// - Free-running x16 clock, group every sixteen
// - Nine-bit select receives and reports ninth bit
// - Disabling receive returns bit recovery to idle and clears overrun; queued words stay
module async_serial_receiver (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial line and request
  input wire logic serial_receive_pin_i,
  output logic receive_request_o
);

  rx_fifo_if fifo ();

  rx_word_store u_store (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .fifo (fifo.store)
  );

  // ==========================================================
  // Software registers
  logic [3:0] control;
  logic [7:0] baud_divisor;
  logic [7:0] enables;
  logic overrun_error;

  wire serial_port_enable = control[rx_serial_pkg::SERIAL_PORT_ENABLE_BIT-4];
  wire nine_bit_receive_select =
    control[rx_serial_pkg::NINE_BIT_SELECT_BIT-4];
  wire continuous_receive_enable = control[rx_serial_pkg::CONT_RECEIVE_BIT-4];
  wire rx_enable = serial_port_enable & continuous_receive_enable;
  wire rx_reset = ~rx_enable;

  // ==========================================================
  // AXI write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  assign s_axi_awready_o = ~aw_held;
  assign s_axi_wready_o = ~w_held;
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire write_fire = aw_held & w_held & ~s_axi_bvalid_o;
  wire wr_control = write_fire & w_lane0 &
                    (aw_addr == rx_serial_pkg::ADDR_RX_CONTROL);
  wire wr_baud = write_fire & w_lane0 &
                 (aw_addr == rx_serial_pkg::ADDR_BAUD_DIVISOR);
  wire wr_enables = write_fire & w_lane0 &
                    (aw_addr == rx_serial_pkg::ADDR_ENABLES);
  // Buffer and flags are read-only but still answer OKAY
  wire wr_mapped = (aw_addr == rx_serial_pkg::ADDR_RX_CONTROL) |
                   (aw_addr == rx_serial_pkg::ADDR_RX_BUFFER) |
                   (aw_addr == rx_serial_pkg::ADDR_BAUD_DIVISOR) |
                   (aw_addr == rx_serial_pkg::ADDR_FLAGS) |
                   (aw_addr == rx_serial_pkg::ADDR_ENABLES);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata_i[7:0];
      w_lane0 <= s_axi_wstrb_i[0];
    end else if (write_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= rx_serial_pkg::RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_mapped ? rx_serial_pkg::RESP_OKAY
                                 : rx_serial_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control <= rx_serial_pkg::CONTROL_RESET;
      baud_divisor <= rx_serial_pkg::BAUD_RESET;
      enables <= rx_serial_pkg::ENABLES_RESET;
    end else begin
      if (wr_control) begin
        control <= w_byte[7:4];
      end
      if (wr_baud) begin
        baud_divisor <= w_byte;
      end
      if (wr_enables) begin
        enables <= w_byte;
      end
    end
  end

  // ==========================================================
  // Baud tick generator
  // divisor+1 clocks per tick, sixteen ticks per bit
  // runs regardless of enable, so ticks never stop
  logic [7:0] baud_count;
  wire tick = (baud_count == 8'h00);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_count <= 8'h00;
    end else begin
      baud_count <= tick ? baud_divisor : baud_count - 8'h01;
    end
  end

  // ==========================================================
  // Bit recovery
  rx_serial_pkg::rx_state_type state;
  rx_serial_pkg::rx_state_type next_state;
  logic [rx_serial_pkg::PHASE_W-1:0] phase;
  logic [1:0] samples;
  logic line_prev;
  logic [3:0] bit_idx;
  logic [8:0] shift_reg;

  // falling edge of idle-high line opens a frame
  wire start_seen = tick & (state == rx_serial_pkg::ST_IDLE) &
                    line_prev & ~serial_receive_pin_i;
  // seventh and eighth edges stored, ninth read live
  wire sample_en = tick & (state != rx_serial_pkg::ST_IDLE) &
                   (phase >= rx_serial_pkg::SAMPLE_FIRST) &
                   (phase < rx_serial_pkg::SAMPLE_LAST);
  wire vote_now = tick & (state != rx_serial_pkg::ST_IDLE) &
                  (phase == rx_serial_pkg::SAMPLE_LAST);
  wire vote = (samples[1] & samples[0]) |
              (samples[1] & serial_receive_pin_i) |
              (samples[0] & serial_receive_pin_i);
  wire [3:0] last_bit = nine_bit_receive_select ?
                        rx_serial_pkg::LAST_BIT_NINE :
                        rx_serial_pkg::LAST_BIT_EIGHT;
  wire stop_done = vote_now & (state == rx_serial_pkg::ST_STOP);

  always_comb begin
    next_state = state;
    case (state)
      rx_serial_pkg::ST_IDLE: begin
        if (start_seen) begin
          next_state = rx_serial_pkg::ST_START;
        end
      end
      rx_serial_pkg::ST_START: begin
        // A high vote means a glitch, not a start bit
        if (vote_now) begin
          next_state = vote ? rx_serial_pkg::ST_IDLE
                            : rx_serial_pkg::ST_DATA;
        end
      end
      rx_serial_pkg::ST_DATA: begin
        if (vote_now && bit_idx == last_bit) begin
          next_state = rx_serial_pkg::ST_STOP;
        end
      end
      rx_serial_pkg::ST_STOP: begin
        // Back to idle at mid stop bit, so the next edge is seen early
        if (vote_now) begin
          next_state = rx_serial_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = rx_serial_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rx_serial_pkg::ST_IDLE;
    end else if (rx_reset) begin
      state <= rx_serial_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // phase counts x16 ticks within each bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= '0;
      line_prev <= 1'b1;
      samples <= 2'h3;
    end else if (tick) begin
      line_prev <= serial_receive_pin_i;
      phase <= start_seen ? rx_serial_pkg::PHASE_AFTER_START
                          : phase + 4'h1;
      if (sample_en) begin
        samples <= {samples[0], serial_receive_pin_i};
      end
    end
  end

  // data bits arrive least significant first
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_idx <= 4'h0;
      shift_reg <= 9'h000;
    end else if (state != rx_serial_pkg::ST_DATA) begin
      bit_idx <= 4'h0;
    end else if (vote_now) begin
      shift_reg[bit_idx] <= vote;
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // ==========================================================
  // Receive queue
  logic [1:0] count;
  logic [rx_serial_pkg::PTR_W-1:0] wr_ptr;
  logic [rx_serial_pkg::PTR_W-1:0] rd_ptr;
  logic pop;

  wire fifo_full = (count == rx_serial_pkg::FIFO_FULL_COUNT);
  // transfer only with space and no overrun
  wire push = stop_done & ~fifo_full & ~overrun_error;
  wire receive_ready_flag = (count != 2'h0);

  assign fifo.wr_en = push;
  assign fifo.wr_ptr = wr_ptr;
  // framing error and ninth bit ride with the word
  assign fifo.wr_data = {~vote,
                         nine_bit_receive_select & shift_reg[8],
                         shift_reg[7:0]};
  assign fifo.next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

  // flag falls only when the last word is read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 2'h0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // set on full, cleared by receive reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun_error <= 1'b0;
    end else if (rx_reset) begin
      overrun_error <= 1'b0;
    end else if (stop_done && fifo_full) begin
      overrun_error <= 1'b1;
    end
  end

  // flag gated by the interrupt enable
  assign receive_request_o = receive_ready_flag &
                             enables[rx_serial_pkg::RECEIVE_IRQ_ENABLE_BIT];

  // ==========================================================
  // AXI read channel
  logic [7:0] read_byte;
  logic read_mapped;

  assign s_axi_arready_o = ~s_axi_rvalid_o;
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire [7:0] status_byte = {control, 1'b0,
                            fifo.rd_data[9] & receive_ready_flag,
                            overrun_error,
                            fifo.rd_data[8] & receive_ready_flag};
  wire [7:0] flags_byte = rx_serial_pkg::FLAGS_FIXED |
                          {7'h00, receive_ready_flag};
  // A buffer read advances the queue, the status shows the next word
  assign pop = ar_take & receive_ready_flag &
               (s_axi_araddr_i == rx_serial_pkg::ADDR_RX_BUFFER);

  always_comb begin
    read_byte = 8'h00;
    read_mapped = 1'b1;
    case (s_axi_araddr_i)
      rx_serial_pkg::ADDR_RX_CONTROL: read_byte = status_byte;
      rx_serial_pkg::ADDR_RX_BUFFER: read_byte = fifo.rd_data[7:0];
      rx_serial_pkg::ADDR_BAUD_DIVISOR: read_byte = baud_divisor;
      rx_serial_pkg::ADDR_FLAGS: read_byte = flags_byte;
      rx_serial_pkg::ADDR_ENABLES: read_byte = enables;
      default: read_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= rx_serial_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, read_byte};
      s_axi_rresp_o <= read_mapped ? rx_serial_pkg::RESP_OKAY
                                   : rx_serial_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_overrun_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    stop_done && fifo_full && rx_enable |=> overrun_error)
    else $error("overrun not flagged on full queue");
  a_overrun_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    overrun_error |=> count <= $past(count))
    else $error("transfer while overrun set");
  a_overrun_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !continuous_receive_enable |=> !overrun_error)
    else $error("overrun kept after receive reset");
  a_disable_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !rx_enable |=> state == rx_serial_pkg::ST_IDLE)
    else $error("receiver active while disabled");
  a_push_empty: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    stop_done && count == 2'h0 && !overrun_error && rx_enable
    |=> count == 2'h1 && receive_ready_flag)
    else $error("word not moved into empty queue");
  a_flag_last_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pop && count == 2'h1 && !push |=> !receive_ready_flag)
    else $error("ready flag stayed after last read");
  a_queue_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    count <= rx_serial_pkg::FIFO_FULL_COUNT)
    else $error("queue count beyond two");
  a_framing_tag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    push && !vote && count == 2'h0 |=> fifo.rd_data[9])
    else $error("missing stop bit not tagged");
  a_vote_phase: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_seen && rx_enable && baud_divisor == 8'h00
    |-> ##8 vote_now)
    else $error("vote outside sample window");

endmodule

// *** logic/rx_serial_pkg.sv ***
// Constants and types shared by the serial receive path
package rx_serial_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_RX_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RX_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;

  // ==========================================================
  // Field positions
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_SELECT_BIT = 6;
  localparam int SINGLE_RECEIVE_BIT = 5;
  localparam int CONT_RECEIVE_BIT = 4;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int NINTH_BIT_BIT = 0;
  localparam int RECEIVE_READY_BIT = 0;
  localparam int RECEIVE_IRQ_ENABLE_BIT = 0;

  // ==========================================================
  // Values after reset
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  // Bit 1 belongs to the absent transmitter; it reads as its reset value
  localparam logic [7:0] FLAGS_FIXED = 8'h02;

  // ==========================================================
  // Oversampling and framing counts
  localparam int OVERSAMPLE = 16;
  localparam int PHASE_W = $clog2(OVERSAMPLE);
  localparam logic [PHASE_W-1:0] PHASE_AFTER_START = 4'h1;
  localparam logic [PHASE_W-1:0] SAMPLE_FIRST = 4'h6;
  localparam logic [PHASE_W-1:0] SAMPLE_LAST = 4'h8;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;

  // ==========================================================
  // Receive queue: {framing error, ninth bit, data byte}
  localparam int FIFO_DEPTH = 2;
  localparam int PTR_W = 1;
  localparam int ENTRY_W = 10;
  localparam logic [1:0] FIFO_FULL_COUNT = 2'h2;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_type;

endpackage

// *** logic/rx_fifo_if.sv ***
// Connection between the receiver and its word store
interface rx_fifo_if;
  logic wr_en;
  logic [rx_serial_pkg::PTR_W-1:0] wr_ptr;
  logic [rx_serial_pkg::ENTRY_W-1:0] wr_data;
  // Address of the head as it will be after this edge
  logic [rx_serial_pkg::PTR_W-1:0] next_rd_ptr;
  logic [rx_serial_pkg::ENTRY_W-1:0] rd_data;

  modport writer (output wr_en, output wr_ptr, output wr_data,
                  output next_rd_ptr, input rd_data);
  modport store (input wr_en, input wr_ptr, input wr_data,
                 input next_rd_ptr, output rd_data);
endinterface

// *** logic/rx_word_store.sv ***
// Two-entry storage for received words with a registered head output
module rx_word_store (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Queue port
  rx_fifo_if.store fifo
);

  logic [rx_serial_pkg::ENTRY_W-1:0] mem [rx_serial_pkg::FIFO_DEPTH];
  logic bypass;

  // ==========================================================
  // Entries
  genvar gi;
  generate
    for (gi = 0; gi < rx_serial_pkg::FIFO_DEPTH; gi++) begin : g_entry
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem[gi] <= '0;
        end else if (fifo.wr_en &&
                     fifo.wr_ptr == rx_serial_pkg::PTR_W'(gi)) begin
          mem[gi] <= fifo.wr_data;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Head register
  // Bypass so a word written into an empty queue is at the head at once
  assign bypass = fifo.wr_en && (fifo.wr_ptr == fifo.next_rd_ptr);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo.rd_data <= '0;
    end else begin
      fifo.rd_data <= bypass ? fifo.wr_data : mem[fifo.next_rd_ptr];
    end
  end

endmodule

// *** verification/serial_tx_model.sv ***
// Behavioural remote transmitter that drives the serial receive line
module serial_tx_model (
  // Clock
  input wire logic ref_clk_i,
  // Serial line
  output logic line_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial line_o = 1'b1;

  // ==========================================================
  // Frame sender
  // Glitch flips one clock mid-bit: it can spoil one vote sample only
  task automatic send(input logic [8:0] data, input int nbits,
      input logic stop, input int bit_clks, input int glitch_bit);
    logic lvl;
    for (int b = 0; b <= nbits + 1; b++) begin
      lvl = (b == 0) ? 1'b0 : (b <= nbits) ? data[b-1] : stop;
      for (int c = 0; c < bit_clks; c++) begin
        @(posedge ref_clk_i);
        line_o <= (b == glitch_bit && c == bit_clks / 2) ? ~lvl : lvl;
      end
    end
    @(posedge ref_clk_i);
    line_o <= 1'b1;
    repeat (bit_clks) @(posedge ref_clk_i);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking testbench for the serial receiver
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_line, request;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [1:0] OK = rx_serial_pkg::RESP_OKAY;
  localparam logic [7:0] CTRL = rx_serial_pkg::ADDR_RX_CONTROL;
  localparam logic [7:0] BUF = rx_serial_pkg::ADDR_RX_BUFFER;
  localparam logic [7:0] FLG = rx_serial_pkg::ADDR_FLAGS;
  localparam logic [7:0] ENA = rx_serial_pkg::ADDR_ENABLES;

  always #50 ref_clk_i = ~ref_clk_i;

  async_serial_receiver dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .serial_receive_pin_i(rx_line),
    .receive_request_o(request));

  serial_tx_model tx (.ref_clk_i(ref_clk_i), .line_o(rx_line));

  // ==========================================================
  // Reporting
  task end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Ceiling well above the nine frames of the run
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus master; handshakes looked at mid-cycle, where they are settled
  task axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic t_aw, t_w, taken;
    logic [1:0] r;
    taken = 1'b0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!taken) begin
      @(negedge ref_clk_i);
      t_aw = awvalid && awready;
      t_w = wvalid && wready;
      taken = bvalid && bready;
      r = bresp;
      @(posedge ref_clk_i);
      if (t_aw) awvalid <= 1'b0;
      if (t_w) wvalid <= 1'b0;
      if (taken) bready <= 1'b0;
    end
    check({30'h0, r}, {30'h0, er});
  endtask

  task rd_check(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er);
    logic t_ar, taken;
    logic [31:0] d;
    logic [1:0] r;
    taken = 1'b0;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!taken) begin
      @(negedge ref_clk_i);
      t_ar = arvalid && arready;
      taken = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge ref_clk_i);
      if (t_ar) arvalid <= 1'b0;
      if (taken) rready <= 1'b0;
    end
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    rd_check(CTRL, 32'h00, OK);
    rd_check(FLG, 32'h02, OK);
    rd_check(rx_serial_pkg::ADDR_BAUD_DIVISOR, 32'h00, OK);
    rd_check(ENA, 32'h00, OK);
    rd_check(8'h14, 32'h00, rx_serial_pkg::RESP_SLVERR);
    axi_write(8'h14, 32'hff, rx_serial_pkg::RESP_SLVERR);
    check({31'h0, request}, 32'h0);
  endtask

  task t_disabled;
    axi_write(CTRL, 32'h80, OK);
    tx.send(9'h055, 8, 1'b1, 16, -1);
    rd_check(FLG, 32'h02, OK);
  endtask

  task t_single;
    axi_write(ENA, 32'h01, OK);
    axi_write(CTRL, 32'h90, OK);
    tx.send(9'h05a, 8, 1'b1, 16, 3);
    rd_check(FLG, 32'h03, OK);
    check({31'h0, request}, 32'h1);
    rd_check(CTRL, 32'h90, OK);
    rd_check(BUF, 32'h5a, OK);
    rd_check(FLG, 32'h02, OK);
    check({31'h0, request}, 32'h0);
    axi_write(FLG, 32'h01, OK);
    rd_check(FLG, 32'h02, OK);
  endtask

  task t_overrun;
    tx.send(9'h011, 8, 1'b0, 16, -1);
    tx.send(9'h022, 8, 1'b1, 16, -1);
    tx.send(9'h033, 8, 1'b1, 16, -1);
    rd_check(CTRL, 32'h96, OK);
    rd_check(BUF, 32'h11, OK);
    rd_check(CTRL, 32'h92, OK);
    // Space exists now, yet the overrun still blocks this word
    tx.send(9'h044, 8, 1'b1, 16, -1);
    rd_check(BUF, 32'h22, OK);
    rd_check(FLG, 32'h02, OK);
    axi_write(CTRL, 32'h80, OK);
    rd_check(CTRL, 32'h80, OK);
    axi_write(CTRL, 32'h90, OK);
    tx.send(9'h066, 8, 1'b1, 16, -1);
    rd_check(BUF, 32'h66, OK);
  endtask

  task t_nine;
    axi_write(ENA, 32'h00, OK);
    axi_write(CTRL, 32'hd0, OK);
    tx.send(9'h1a5, 9, 1'b1, 16, -1);
    check({31'h0, request}, 32'h0);
    rd_check(CTRL, 32'hd1, OK);
    rd_check(BUF, 32'ha5, OK);
  endtask

  task t_baud;
    axi_write(CTRL, 32'h90, OK);
    axi_write(rx_serial_pkg::ADDR_BAUD_DIVISOR, 32'h01, OK);
    tx.send(9'h03c, 8, 1'b1, 32, -1);
    rd_check(BUF, 32'h3c, OK);
    rd_check(rx_serial_pkg::ADDR_BAUD_DIVISOR, 32'h01, OK);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_disabled();
    t_single();
    t_overrun();
    t_nine();
    t_baud();
    end_of_test();
  end
endmodule
